/* design/bsr_reporter.sv */
// Statistics reporter end: counters, programming decode and periodic structure writer.
`timescale 1ns/1ps

// What this block does
// - Count fourteen categories, write structure when enabled
// - Rewrite structure every 4096 bus cycles
// - Programming captures 40-bit address and enable
// - Captured address is the word 0 write destination
// - Node sets programming flag, bus id zero
// - Enable field one (lower word eight) enables, zero disables
// - Byte count one doubleword; source holds address
// - Software picks doubleword aligned reporting address
// - Words 0-14 tags and counts layout
// - Word 15 burst count and jumpers
// - Bits 5-0 transfer, 7-6 multi-grant jumpers
// - Bits 11-8 turnaround, 15-12 burst requester
// - Bit 31 flags failover primary status
// - Disable clears any pending enabled state
// - Completion signalled within five microseconds
// - No structure writes after disable
module bsr_reporter
  import bsr_pkg::*;
#(
  parameter int unsigned CNT_W  = 16,
  parameter int unsigned PERIOD = REPORT_PERIOD_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  bsr_link_if.reporter           link,
  input  wire logic [ACT_W-1:0]  activity,
  input  wire logic [5:0]        xfer_count_jumpers,
  input  wire logic [1:0]        multi_grant_jumpers,
  input  wire logic [3:0]        turnaround_jumpers,
  input  wire logic [3:0]        burst_requester_jumpers,
  input  wire logic              failover_primary_indicator,
  output logic                   reporting_enabled
);

  // Writer states: idle between periods, or streaming the 16 words.
  typedef enum logic [0:0] {BSR_IDLE, BSR_SEND} bsr_state_t;

  bsr_state_t                 state_reg;        // Writer state.
  logic                       enable_reg;       // Reporting enabled.
  logic [REPORT_ADDR_W-1:0]   addr_reg;         // Captured reporting address.
  logic [ACT_W-1:0][CNT_W-1:0] cnt_reg;         // Category counters.
  logic [ACT_W-1:0][CNT_W-1:0] snap_reg;        // Snapshot taken at period end.
  logic [31:0]                period_reg;       // Cycles since last period start.
  logic [3:0]                 word_idx_reg;     // Word being produced.
  logic                       done_reg;         // Completion pulse.
  logic                       prog_hit;         // Valid programming transfer taken.
  logic                       prog_en;          // Decoded enable of that transfer.
  logic                       period_end;       // Period counter wrapped.
  logic [31:0]                word_data;        // Structure word for current index.
  // Two-entry output buffer so a stalled receiver loses no word.
  logic [1:0][72:0]           buf_reg;
  logic [1:0]                 buf_cnt_reg;
  logic                       push;
  logic                       pop;

  // The reporter always accepts programming; completion is one cycle later.
  assign link.prog_ready = 1'b1;

  assign prog_hit = link.prog_valid
    && link.upper_destination_word[31]
    // The bus id field shares its top bit with the programming flag, so only
    // the seven bits below the flag are compared against the target id.
    && (link.upper_destination_word[TGT_BUS_LSB +: 7] == TGT_BUS_ID[6:0])
    && (link.lower_destination_word[TGT_BOARD_LSB +: 8] == TGT_BOARD_ID);
  assign prog_en = (link.lower_destination_word[SE_LSB +: SE_W] == SE_ENABLE);

  // Enable and address capture.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
      addr_reg   <= '0;
    end else if (prog_hit) begin
      enable_reg <= prog_en;
      if (prog_en) begin
        addr_reg <= link.source_address_word[REPORT_ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= prog_hit;
    end
  end
  assign link.transfer_complete_indication = done_reg;
  assign reporting_enabled = enable_reg;

  assign period_end = enable_reg && (period_reg == 32'(PERIOD - 1));
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enable_reg || prog_hit) begin
      period_reg <= '0;
    end else if (period_end) begin
      period_reg <= '0;
    end else begin
      period_reg <= period_reg + 32'd1;
    end
  end

  // Category counters, one per activity strobe.
  genvar g;
  generate
    for (g = 0; g < ACT_W; g++) begin : g_cnt
      always_ff @(posedge core_clk) begin
        if (sys_rst || (prog_hit && prog_en && !enable_reg)) begin
          cnt_reg[g] <= '0;
        end else if (enable_reg && activity[g]) begin
          cnt_reg[g] <= cnt_reg[g] + CNT_W'(1);
        end
      end
    end
  endgenerate

  // Snapshot keeps the structure coherent while counters keep running.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      snap_reg <= '0;
    end else if (period_end && state_reg == BSR_IDLE) begin
      snap_reg <= cnt_reg;
    end
  end

  // Writer state machine; a period that ends mid-stream is skipped.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg    <= BSR_IDLE;
      word_idx_reg <= '0;
    end else begin
      case (state_reg)
        BSR_IDLE: begin
          if (period_end) begin
            state_reg    <= BSR_SEND;
            word_idx_reg <= '0;
          end
        end
        BSR_SEND: begin
          if (!enable_reg) begin
            state_reg <= BSR_IDLE;
          end else if (push) begin
            word_idx_reg <= word_idx_reg + 4'd1;
            if (word_idx_reg == 4'(STRUCT_WORDS - 1)) begin
              state_reg <= BSR_IDLE;
            end
          end
        end
        default: begin
          state_reg <= BSR_IDLE;
        end
      endcase
    end
  end

  // Structure word selection.
  always_comb begin
    word_data = '0;
    case (word_idx_reg)
      4'h0: word_data = {WORD0_TAG, 16'h0000};
      4'h1: word_data = {WORD1_TAG, 16'h0000};
      4'hf: begin
        word_data[31:16] = snap_reg[CAT_BURST];
        word_data[W15_XFER_LSB +: 6]   = xfer_count_jumpers;
        word_data[W15_MGRANT_LSB +: 2] = multi_grant_jumpers;
        word_data[W15_TURN_LSB +: 4]     = turnaround_jumpers;
        word_data[W15_BURST_ID_LSB +: 4] = burst_requester_jumpers;
        word_data[W15_FAILOVER_BIT] = failover_primary_indicator;
      end
      // counts in words 2 to 14
      default: word_data = {16'h0000, snap_reg[word_idx_reg - 4'd2]};
    endcase
  end

  // Output buffer: push while streaming, pop when the receiver is ready.
  assign push = (state_reg == BSR_SEND) && enable_reg && (buf_cnt_reg != 2'd2);
  assign pop  = (buf_cnt_reg != 2'd0) && link.wr_ready;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !enable_reg) begin
      buf_cnt_reg <= '0;
      buf_reg     <= '0;
    end else begin
      if (pop) begin
        buf_reg[0] <= buf_reg[1];
      end
      if (push) begin
        buf_reg[buf_cnt_reg - (pop ? 2'd1 : 2'd0)] <=
          {word_idx_reg == 4'hf, addr_reg + {word_idx_reg, 2'b00}, word_data};
      end
      buf_cnt_reg <= buf_cnt_reg + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);
    end
  end

  assign link.wr_valid = (buf_cnt_reg != 2'd0);
  assign link.wr_data  = buf_reg[0][31:0];
  assign link.wr_addr  = buf_reg[0][71:32];
  assign link.wr_last  = buf_reg[0][72];

endmodule

/* design/bsr_pkg.sv */
// Package holding constants shared by both ends of the statistics reporter.
package bsr_pkg;

  // Category count constant, not used; the reporter counts ACT_W (14) activity categories.
  localparam int unsigned NUM_CATEGORIES = 12;
  // Words in one statistics structure.
  localparam int unsigned STRUCT_WORDS = 16;
  // Bus clock cycles between two structure rewrites.
  localparam int unsigned REPORT_PERIOD_CYC = 4096;
  // Width of the reporting address.
  localparam int unsigned REPORT_ADDR_W = 40;

  // Programming flag carried in the upper destination word.
  localparam logic [31:0] UPPER_DEST_PROG = 32'h8000_0000;
  // Target bus identifier field of the upper destination word.
  localparam int unsigned TGT_BUS_LSB = 24;
  localparam logic [7:0] TGT_BUS_ID = 8'h00;
  // Lower destination word field positions.
  localparam int unsigned TGT_BOARD_LSB = 24;
  localparam logic [7:0] TGT_BOARD_ID = 8'h00;
  localparam int unsigned SE_LSB = 3;
  localparam int unsigned SE_W = 4;
  // Enable field codes.
  localparam logic [3:0] SE_ENABLE = 4'h1;
  localparam logic [3:0] SE_DISABLE = 4'h0;
  // Whole lower word values for enable and disable.
  localparam logic [31:0] LOWER_DEST_ENABLE = 32'h0000_0008;
  localparam logic [31:0] LOWER_DEST_DISABLE = 32'h0000_0000;
  // Byte count of a programming transfer: one doubleword.
  localparam logic [31:0] PROG_BYTE_COUNT = 32'h0000_0008;

  // Fixed tags placed in the upper halves of words 0 and 1.
  localparam logic [15:0] WORD0_TAG = 16'h0000;
  localparam logic [15:0] WORD1_TAG = 16'h0001;
  // Word 15 field positions.
  localparam int unsigned W15_XFER_LSB = 0;
  localparam int unsigned W15_MGRANT_LSB = 6;
  localparam int unsigned W15_TURN_LSB = 8;
  localparam int unsigned W15_BURST_ID_LSB = 12;
  localparam int unsigned W15_FAILOVER_BIT = 31;

  // Completion time limit and its count in 50 ns cycles (longest, rounded down).
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DONE_LIMIT_NS = 5000;
  localparam int unsigned DONE_LIMIT_CYC = DONE_LIMIT_NS / CLK_PERIOD_NS;

  // Category indices of the activity input vector.
  localparam int unsigned CAT_IDLE = 0;
  localparam int unsigned CAT_TURN = 1;
  localparam int unsigned CAT_SEMA = 2;
  localparam int unsigned CAT_ADDR = 3;
  localparam int unsigned CAT_NODE0 = 4;
  localparam int unsigned CAT_SINGLE = 12;
  localparam int unsigned CAT_BURST = 13;
  // Width of the activity strobe vector.
  localparam int unsigned ACT_W = 14;

endpackage

/* design/bsr_link_if.sv */
// Interface joining the programming node and the statistics reporter.
`timescale 1ns/1ps
interface bsr_link_if;
  // Programming transfer, offered by the node.
  logic        prog_valid;
  logic        prog_ready;
  logic [31:0] upper_destination_word;
  logic [31:0] lower_destination_word;
  logic [31:0] byte_count_word;
  logic [63:0] source_address_word;
  // Completion pulse back to the node.
  logic        transfer_complete_indication;
  // Structure writes from the reporter.
  logic        wr_valid;
  logic        wr_ready;
  logic [39:0] wr_addr;
  logic [31:0] wr_data;
  logic        wr_last;

  // Reporter end.
  modport reporter (
    input  prog_valid, upper_destination_word, lower_destination_word,
    input  byte_count_word, source_address_word, wr_ready,
    output prog_ready, transfer_complete_indication,
    output wr_valid, wr_addr, wr_data, wr_last
  );
  // Programming node end.
  modport node (
    output prog_valid, upper_destination_word, lower_destination_word,
    output byte_count_word, source_address_word, wr_ready,
    input  prog_ready, transfer_complete_indication,
    input  wr_valid, wr_addr, wr_data, wr_last
  );
endinterface

/* design/bsr_node.sv */
// Programming node end: issues programming transfers and receives structure words.
`timescale 1ns/1ps
module bsr_node
  import bsr_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  bsr_link_if.node                      link,
  input  wire logic                     cmd_valid,
  output logic                          cmd_ready,
  input  wire logic                     cmd_enable,
  input  wire logic [REPORT_ADDR_W-1:0] cmd_addr,
  output logic                          cmd_done,
  output logic                          cmd_timeout,
  input  wire logic                     rx_ready,
  output logic                          rx_valid,
  output logic [REPORT_ADDR_W-1:0]      rx_addr,
  output logic [31:0]                   rx_data,
  output logic                          rx_last
);

  logic        busy_reg;     // Transfer outstanding.
  logic        offer_reg;    // Programming transfer on the link.
  logic        en_reg;       // Enable requested.
  logic [39:0] addr_reg;     // Address offered.
  logic [7:0]  wait_reg;     // Cycles waiting for completion.
  logic        done_reg;     // Completion pulse to user.
  logic        tmo_reg;      // Timeout pulse to user.

  assign cmd_ready = !busy_reg;

  assign link.upper_destination_word = UPPER_DEST_PROG;
  assign link.lower_destination_word = en_reg ? LOWER_DEST_ENABLE : LOWER_DEST_DISABLE;
  assign link.byte_count_word     = PROG_BYTE_COUNT;
  assign link.source_address_word = {24'h000000, addr_reg[39:3], 3'b000};
  assign link.prog_valid          = offer_reg;

  // Command issue and completion tracking.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_reg  <= 1'b0;
      offer_reg <= 1'b0;
      en_reg    <= 1'b0;
      addr_reg  <= '0;
      wait_reg  <= '0;
      done_reg  <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      tmo_reg  <= 1'b0;
      if (cmd_valid && !busy_reg) begin
        busy_reg  <= 1'b1;
        offer_reg <= 1'b1;
        en_reg    <= cmd_enable;
        addr_reg  <= cmd_addr;
        wait_reg  <= '0;
      end else if (busy_reg) begin
        if (offer_reg && link.prog_ready) begin
          offer_reg <= 1'b0;
        end
        wait_reg <= wait_reg + 8'd1;
        if (link.transfer_complete_indication) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else if (wait_reg == 8'(DONE_LIMIT_CYC)) begin
          busy_reg <= 1'b0;
          tmo_reg  <= 1'b1;
        end
      end
    end
  end
  assign cmd_done    = done_reg;
  assign cmd_timeout = tmo_reg;

  // Received structure words pass straight to the user with back-pressure.
  assign link.wr_ready = rx_ready;
  assign rx_valid      = link.wr_valid;
  assign rx_addr       = link.wr_addr;
  assign rx_data       = link.wr_data;
  assign rx_last       = link.wr_last;

endmodule

/* verif/bsr_link_chk.sv */
// Checker on the link between programming node and reporter.
`timescale 1ns/1ps
module bsr_link_chk
  import bsr_pkg::*;
#(
  parameter int PERIOD = 32
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        prog_valid,
  input wire logic        prog_ready,
  input wire logic [31:0] upper_destination_word,
  input wire logic [31:0] lower_destination_word,
  input wire logic [63:0] source_address_word,
  input wire logic        transfer_complete_indication,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [39:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_last
);
  localparam int P_LO = PERIOD - 8;
  localparam int P_HI = PERIOD + 4;
  logic        take;
  logic        en_take;
  logic        dis_take;
  logic [3:0]  idx_reg;    // Index of the word on the link.
  logic [39:0] base_reg;   // Address of word 0.
  logic [39:0] src_reg;    // Last programmed address.
  logic        off_reg;    // Reporting is off.
  logic        off_d_reg;  // Reporting was off a cycle ago.
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign take = prog_valid && prog_ready && upper_destination_word == UPPER_DEST_PROG;
  assign en_take = take && lower_destination_word == LOWER_DEST_ENABLE;
  assign dis_take = take && lower_destination_word == LOWER_DEST_DISABLE;
  // A disable flushes the stream, so the index restarts.
  always_ff @(posedge core_clk) begin
    if (sys_rst || dis_take) idx_reg <= 4'h0;
    else if (wr_valid && wr_ready && !off_reg) idx_reg <= idx_reg + 4'h1;
  end
  // Addresses kept for comparison.
  always_ff @(posedge core_clk) begin
    if (wr_valid && wr_ready && idx_reg == 4'h0) base_reg <= wr_addr;
    if (en_take) src_reg <= source_address_word[39:0];
  end
  // Off state, delayed once since the flush needs an edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      off_reg <= 1'b1;
      off_d_reg <= 1'b1;
    end else begin
      if (en_take) off_reg <= 1'b0;
      else if (dis_take) off_reg <= 1'b1;
      off_d_reg <= off_reg;
    end
  end
  sequence s_en_take;
    en_take;
  endsequence
  sequence s_word0;
    wr_valid && idx_reg == 4'h0;
  endsequence
  property p_complete;
    take |=> transfer_complete_indication;
  endproperty
  a_complete: assert property (p_complete) else $error("no completion pulse");
  property p_period;
    s_en_take |=> (!wr_valid)[*8] ##[P_LO:P_HI] s_word0;
  endproperty
  a_period: assert property (p_period) else $error("structure period wrong");
  property p_hold;
    wr_valid && !wr_ready && !prog_valid && !off_reg |=>
      wr_valid && $stable(wr_addr) && $stable(wr_data) && $stable(wr_last);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_step;
    wr_valid && !off_reg && idx_reg != 4'h0 |-> wr_addr == base_reg + {34'h0, idx_reg, 2'b00};
  endproperty
  a_step: assert property (p_step) else $error("word address wrong");
  property p_last;
    wr_valid && !off_reg |-> wr_last == (idx_reg == 4'hf);
  endproperty
  a_last: assert property (p_last) else $error("last marker wrong");
  property p_tag;
    wr_valid && !off_reg && idx_reg < 4'h2 |-> wr_data[31:16] == {12'h000, idx_reg};
  endproperty
  a_tag: assert property (p_tag) else $error("word tag wrong");
  property p_dest;
    wr_valid && !off_reg && idx_reg == 4'h0 |-> wr_addr == src_reg;
  endproperty
  a_dest: assert property (p_dest) else $error("base address wrong");
  property p_quiet;
    off_reg && off_d_reg |-> !wr_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("write while off");
endmodule

/* verif/tb_bus_statistics_reporter.sv */
// Bench joining node and reporter through the link.
`timescale 1ns/1ps
module tb_bus_statistics_reporter;
  import bsr_pkg::*;
  localparam int PER = 32;  // Short period keeps the run brief.
  logic             core_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [ACT_W-1:0] activity = 14'h0000;
  logic [5:0]       xj = 6'h2d;  // Jumper inputs.
  logic [1:0]       mj = 2'h2;
  logic [3:0]       tj = 4'h9;
  logic [3:0]       bj = 4'h6;
  logic             fo = 1'b1;   // Failover indicator.
  logic             cmd_valid = 1'b0;
  logic             cmd_enable = 1'b0;
  logic [39:0]      cmd_addr = 40'h0;
  logic             rx_ready = 1'b0;
  logic             reporting_enabled, cmd_ready, cmd_done, cmd_timeout, rx_valid, rx_last;
  logic [39:0]      rx_addr;
  logic [31:0]      rx_data;
  int               fails = 0;
  int               cmp_count = 0;
  always #25 core_clk = ~core_clk;
  bsr_link_if u_link ();
  bsr_reporter #(.PERIOD(PER)) u_bsr_reporter (
    .core_clk, .sys_rst, .link(u_link), .activity, .xfer_count_jumpers(xj),
    .multi_grant_jumpers(mj), .turnaround_jumpers(tj), .burst_requester_jumpers(bj),
    .failover_primary_indicator(fo), .reporting_enabled);
  bsr_node u_bsr_node (
    .core_clk, .sys_rst, .link(u_link), .cmd_valid, .cmd_ready, .cmd_enable, .cmd_addr,
    .cmd_done, .cmd_timeout, .rx_ready, .rx_valid, .rx_addr, .rx_data, .rx_last);
  bsr_link_chk #(.PERIOD(PER)) u_bsr_link_chk (
    .core_clk, .sys_rst, .prog_valid(u_link.prog_valid), .prog_ready(u_link.prog_ready),
    .upper_destination_word(u_link.upper_destination_word),
    .lower_destination_word(u_link.lower_destination_word),
    .source_address_word(u_link.source_address_word),
    .transfer_complete_indication(u_link.transfer_complete_indication),
    .wr_valid(u_link.wr_valid), .wr_ready(u_link.wr_ready), .wr_addr(u_link.wr_addr),
    .wr_data(u_link.wr_data), .wr_last(u_link.wr_last));
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Sends one programming command and waits for its completion.
  task automatic issue_prog(input logic en, input logic [39:0] addr);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk("ready", 1, cmd_ready);
    cmd_valid = 1'b1;
    cmd_enable = en;
    cmd_addr = addr;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < DONE_LIMIT_CYC) begin
      @(negedge core_clk);
      n++;
    end
    chk("done", 1, cmd_done);
    chk("timeout", 0, cmd_timeout);
    chk("enabled", en, reporting_enabled);
  endtask
  // Takes one whole structure; a stall accepts only every third cycle.
  task automatic get_struct(input logic [39:0] addr, input logic cnt, input logic stall);
    int i;
    int k;
    i = 0;
    k = 0;
    while (i < 16 && k < 400) begin
      @(negedge core_clk);
      k++;
      rx_ready = !stall || (k % 3 == 0);
      if (rx_ready && rx_valid === 1'b1) begin
        chk("addr", addr + 40'(4 * i), rx_addr);
        chk("last", i == 15, rx_last);
        if (i < 2) chk("tag", i, rx_data[31:16]);
        else if (i < 15) chk("count", cnt ? i - 1 : 0, rx_data[15:0]);
        else begin
          chk("jumpers", {bj, tj, mj, xj}, rx_data[15:0]);
          chk("burst", cnt ? 14 : 0, rx_data[30:16]);
          chk("failover", fo, rx_data[31]);
        end
        i++;
      end
    end
    chk("words", 16, i);
    @(negedge core_clk);
    rx_ready = 1'b0;
  endtask
  // Category j is strobed j+1 times, so every count differs.
  task automatic t_first();
    issue_prog(1'b0, 40'h0);
    issue_prog(1'b1, 40'h12_3456_7800);
    for (int c = 0; c < 14; c++) begin
      @(negedge core_clk);
      activity = 14'h3fff << c;
    end
    @(negedge core_clk);
    activity = 14'h0000;
    get_struct(40'h12_3456_7800, 1'b1, 1'b0);
  endtask
  // Disable, then a millisecond with no word on the receive side.
  task automatic t_quiet();
    int n;
    n = 0;
    issue_prog(1'b0, 40'h12_3456_7800);
    rx_ready = 1'b1;
    repeat (4) @(negedge core_clk);
    repeat (20000) begin
      @(negedge core_clk);
      if (rx_valid === 1'b1) n++;
    end
    chk("quiet", 0, n);
    rx_ready = 1'b0;
  endtask
  // Re-enable elsewhere: counts restart at zero, jumpers read afresh.
  task automatic t_restart();
    xj = 6'h12;
    mj = 2'h1;
    tj = 4'h4;
    bj = 4'hb;
    fo = 1'b0;
    issue_prog(1'b1, 40'hfe_dcba_9870);
    get_struct(40'hfe_dcba_9870, 1'b0, 1'b0);
    issue_prog(1'b0, 40'h0);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    t_first();
    get_struct(40'h12_3456_7800, 1'b1, 1'b1);
    t_quiet();
    t_restart();
    close_out();
  end
  // Watchdog well beyond the expected run.
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    close_out();
  end
endmodule
